// [logic/csp_pkg.sv]
// shared constants and types of the core special-function register block
package csp_pkg;
	localparam int PC_W = 11;
	localparam int DATA_W = 8;
	localparam int LOC_W = 7;
	localparam int BANK_W = 2;

	// r-page offsets of the registers held here
	localparam logic [6:0] ADDR_INDIRECT = 7'h00;
	localparam logic [6:0] ADDR_TIMER0 = 7'h01;
	localparam logic [6:0] ADDR_PC_LOW = 7'h02;
	localparam logic [6:0] ADDR_STATUS = 7'h03;
	// r-page sfr window, mirrored into every bank
	localparam logic [6:0] ADDR_SFR_LAST = 7'h1F;

	// core_status field positions
	localparam int ST_CARRY = 0;
	localparam int ST_HALF = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_SPARE = 5;
	localparam int ST_BANK_LO = 6;
	localparam int ST_BANK_HI = 7;

	// reset values, then fixed read, bank and step constants
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic [7:0] TIMER0_RST = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [1:0] BANK_NONE = 2'h0;
	localparam logic [10:0] PC_STEP = 11'h001;
	localparam logic [7:0] T0_STEP = 8'h01;

	// timer0 source selection codes
	localparam logic T0_MODE_INST = 1'b0;
	localparam logic T0_CFG_LFO = 1'b1;

	// instruction classes signalled by the execution unit
	typedef enum logic [3:0] {
		OP_GENERAL = 4'h0,
		OP_LONG_JUMP = 4'h1,
		OP_LONG_CALL = 4'h2,
		OP_SLEEP = 4'h3,
		OP_WDT_CLEAR = 4'h4,
		OP_F_WR = 4'h5,
		OP_F_RD = 4'h6,
		OP_S_WR = 4'h7,
		OP_S_RD = 4'h8,
		OP_T_WR = 4'h9,
		OP_T_RD = 4'hA,
		OP_PC_LOAD = 4'hB
	} csp_op_t;

	typedef enum logic [1:0] {
		ALU_NONE = 2'h0,
		ALU_ADD = 2'h1,
		ALU_SUB = 2'h2,
		ALU_LOGIC = 2'h3
	} csp_alu_t;

	// register pages, one-hot
	typedef enum logic [3:0] {
		PG_R = 4'b0001,
		PG_F = 4'b0010,
		PG_S = 4'b0100,
		PG_T = 4'b1000
	} csp_page_t;

	typedef struct packed {
		csp_op_t op;
		logic rd;
		logic wr;
		logic [6:0] addr;
		logic [7:0] wdata;
		logic [10:0] target;
	} csp_instr_t;

	typedef struct packed {
		csp_alu_t kind;
		logic carry;
		logic half;
		logic [7:0] result;
	} csp_alu_res_t;

	typedef struct packed {
		logic valid;
		logic rd;
		logic wr;
		csp_page_t page;
		logic [1:0] bank;
		logic [6:0] loc;
		logic [7:0] wdata;
	} csp_mem_req_t;
endpackage : csp_pkg

// [logic/csp_timer0.sv]
// timer0 counter with source selection and pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module csp_timer0 import csp_pkg::*; (
	input wire logic mclk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic clk_en, // freezes all state when low
	input wire logic instruction_clock, // one-cycle tick per instruction
	input wire logic external_count_pin, // asynchronous count pin
	input wire logic lfo_pin, // low-frequency oscillator, other domain
	input wire logic timer0_source_mode, // 0 instruction clock, 1 pin or lfo
	input wire logic cfg_lfo_sel, // configuration word: lfo instead of pin
	input wire logic wr_en, // load request
	input wire logic [7:0] wr_data, // value to load
	output logic [7:0] count_q // live count
);
	logic [2:0] ext_q, ext_d;
	logic [2:0] lfo_q, lfo_d;
	logic [7:0] count_d;
	logic tick;

	// two sync stages, third stage only for rising-edge detect
	always_comb begin
		ext_d = {ext_q[1:0], external_count_pin};
		lfo_d = {lfo_q[1:0], lfo_pin};
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ext_q <= 3'h0;
			lfo_q <= 3'h0;
		end else if (clk_en) begin
			ext_q <= ext_d;
			lfo_q <= lfo_d;
		end
	end

	// source mux, then count; a write replaces the running value
	always_comb begin
		if (timer0_source_mode == T0_MODE_INST) begin // [R8]
			tick = instruction_clock;
		end else if (cfg_lfo_sel == T0_CFG_LFO) begin
			tick = lfo_q[1] & ~lfo_q[2];
		end else begin
			tick = ext_q[1] & ~ext_q[2];
		end
		count_d = count_q;
		if (wr_en) begin
			count_d = wr_data; // [R7]
		end else if (tick) begin
			count_d = count_q + T0_STEP;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_q <= TIMER0_RST;
		end else if (clk_en) begin
			count_q <= count_d;
		end
	end
endmodule : csp_timer0
`default_nettype wire

// [logic/csp_core_sfr.sv]
// core sfr block: page decode, indirect port, timer0, pc low byte, core status
//
// Behaviour
// R1 - f-page only via f_page_write/f_page_read
// R2 - s-page only via s_page_write/s_page_read
// R3 - t-page only via t_page_write/t_page_read
// R4 - f/s-page access ignores bank_select bits
// R5 - indirect port acts on pointed register
// R6 - timer0_count read returns live count
// R7 - timer0_count write replaces running count
// R8 - timer0 source: instruction, pin or lfo
// R9 - pc_low_byte is pc low eight, reset zero
// R10 - pc advances by one per instruction
// R11 - pc high bits only via pc_high_buffer
// R12 - long_jump loads all eleven pc bits
// R13 - long_call loads pc, pushes next address
// R14 - carry: add carry, subtract no borrow
// R15 - half carry from low nibble likewise
// R16 - zero flag from logical result
// R17 - power_down_flag set powerup/clear, sleep clears
// R18 - watchdog_expiry_flag set; timeout clears it
// R19 - bank_select picks one of four banks
// R20 - spare_status_bit is plain storage bit
// R21 - indirect: bank bits plus pointer low seven
// R22 - direct: bank bits plus opcode low seven
// R23 - pc_low_byte write loads high from buffer
`timescale 1ns/1ps
`default_nettype none
module csp_core_sfr import csp_pkg::*; (
	input wire logic mclk, // core clock, 100 MHz
	input wire logic rstn, // async reset, active low
	input wire logic clk_en, // freezes all state when low
	input wire logic exec_valid, // one instruction completes this cycle
	input wire csp_instr_t instr, // class, access and operands
	input wire csp_alu_res_t alu, // alu result of the instruction
	input wire logic wdt_timeout, // watchdog expiry pulse
	input wire logic [7:0] file_select_pointer, // pointer register value
	input wire logic [2:0] pc_high_buffer, // staged pc high bits
	input wire logic instruction_clock, // instruction tick for timer0
	input wire logic external_count_pin, // timer0 count pin
	input wire logic lfo_pin, // low-frequency oscillator
	input wire logic timer0_source_mode, // timer0 source mode bit
	input wire logic cfg_lfo_sel, // configuration word lfo select
	output logic [10:0] pc_q, // program counter
	output logic [7:0] core_status_q, // status register
	output logic [7:0] timer0_count_q, // live timer0 count
	output logic [7:0] rd_data_q, // read data of a local register
	output logic rd_valid_q, // rd_data_q valid, one cycle
	output logic stack_push_q, // push request, one cycle
	output logic [10:0] stack_data_q, // return address to push
	output csp_mem_req_t mem_req_q // decoded request to data memory
);
	// local decode signals
	logic is_r_access;
	logic is_rd;
	logic is_wr;
	logic indirect;
	logic [6:0] eff_loc;
	logic hit_local;
	logic hit_t0;
	logic hit_pcl;
	logic hit_st;
	logic t0_wr;
	logic [1:0] bank;

	// registered next values
	logic [10:0] pc_d;
	logic [7:0] st_d;
	logic [7:0] rd_data_d;
	logic rd_valid_d;
	logic push_d;
	logic [10:0] push_data_d;
	csp_mem_req_t req_d;
	logic [10:0] pc_next_seq;

	assign bank = core_status_q[ST_BANK_HI:ST_BANK_LO];
	assign pc_next_seq = pc_q + PC_STEP;

	// r-page access decode; only general instructions reach r-page
	always_comb begin
		is_r_access = (instr.op == OP_GENERAL) && (instr.rd || instr.wr);
		is_rd = is_r_access && instr.rd;
		is_wr = is_r_access && instr.wr;
		indirect = (instr.addr == ADDR_INDIRECT);
		// indirect port has no storage: follow the pointer
		if (indirect) begin
			eff_loc = file_select_pointer[6:0]; // [R5] [R21]
		end else begin
			eff_loc = instr.addr; // [R22]
		end
		// sfrs exist only in bank 0 and mirror into the others
		hit_t0 = (eff_loc == ADDR_TIMER0);
		hit_pcl = (eff_loc == ADDR_PC_LOW);
		hit_st = (eff_loc == ADDR_STATUS);
		hit_local = hit_t0 || hit_pcl || hit_st || (eff_loc == ADDR_INDIRECT);
		t0_wr = exec_valid && is_wr && hit_t0; // [R7]
	end

	csp_timer0 u_timer0 (
		.mclk(mclk),
		.rstn(rstn),
		.clk_en(clk_en),
		.instruction_clock(instruction_clock),
		.external_count_pin(external_count_pin),
		.lfo_pin(lfo_pin),
		.timer0_source_mode(timer0_source_mode),
		.cfg_lfo_sel(cfg_lfo_sel),
		.wr_en(t0_wr),
		.wr_data(instr.wdata),
		.count_q(timer0_count_q)
	);

	// memory request decode: page chosen by instruction class
	always_comb begin
		req_d = '0;
		req_d.page = PG_R;
		req_d.wdata = instr.wdata;
		req_d.loc = instr.addr;
		req_d.bank = bank;
		if (exec_valid) begin
			unique case (instr.op)
				OP_F_WR, OP_F_RD: begin
					req_d.valid = 1'b1; // [R1]
					req_d.page = PG_F;
					req_d.wr = (instr.op == OP_F_WR);
					req_d.rd = (instr.op == OP_F_RD);
					req_d.bank = BANK_NONE; // [R4]
				end
				OP_S_WR, OP_S_RD: begin
					req_d.valid = 1'b1; // [R2]
					req_d.page = PG_S;
					req_d.wr = (instr.op == OP_S_WR);
					req_d.rd = (instr.op == OP_S_RD);
					req_d.bank = BANK_NONE; // [R4]
				end
				OP_T_WR, OP_T_RD: begin
					req_d.valid = 1'b1; // [R3]
					req_d.page = PG_T;
					req_d.wr = (instr.op == OP_T_WR);
					req_d.rd = (instr.op == OP_T_RD);
				end
				OP_GENERAL: begin
					// general data ops never select f, s or t pages
					req_d.valid = is_r_access && !hit_local; // [R1] [R2] [R3]
					req_d.rd = is_rd;
					req_d.wr = is_wr;
					req_d.loc = eff_loc;
					req_d.bank = bank; // [R19] [R21] [R22]
				end
				default: begin
					req_d.valid = 1'b0;
				end
			endcase
		end
	end

	// local read path: answered here, one cycle after the instruction
	always_comb begin
		rd_data_d = rd_data_q;
		rd_valid_d = 1'b0;
		if (exec_valid && is_rd && hit_local) begin
			rd_valid_d = 1'b1;
			if (hit_t0) begin
				rd_data_d = timer0_count_q; // [R6]
			end else if (hit_pcl) begin
				rd_data_d = pc_q[7:0]; // [R9]
			end else if (hit_st) begin
				rd_data_d = core_status_q;
			end else begin
				// pointer aimed at the indirect port itself
				rd_data_d = READ_ZERO;
			end
		end
	end

	// program counter; high bits never written from the data bus
	always_comb begin
		pc_d = pc_q;
		push_d = 1'b0;
		push_data_d = stack_data_q;
		if (exec_valid) begin
			unique case (instr.op)
				OP_LONG_JUMP: begin
					pc_d = instr.target; // [R12]
				end
				OP_LONG_CALL: begin
					pc_d = instr.target; // [R13]
					push_d = 1'b1;
					push_data_d = pc_next_seq; // [R13]
				end
				OP_PC_LOAD: begin
					pc_d = instr.target;
				end
				default: begin
					if (is_wr && hit_pcl) begin
						pc_d = {pc_high_buffer, instr.wdata}; // [R11] [R23]
					end else begin
						pc_d = pc_next_seq; // [R10]
					end
				end
			endcase
		end
	end

	// status flags; hardware updates follow software writes so they win
	always_comb begin
		st_d = core_status_q;
		if (exec_valid) begin
			if (is_wr && hit_st) begin
				st_d = instr.wdata; // [R19] [R20]
			end
			unique case (alu.kind)
				ALU_ADD: begin
					st_d[ST_CARRY] = alu.carry; // [R14]
					st_d[ST_HALF] = alu.half; // [R15]
				end
				ALU_SUB: begin
					// carry inputs carry the borrow for subtraction
					st_d[ST_CARRY] = ~alu.carry; // [R14]
					st_d[ST_HALF] = ~alu.half; // [R15]
				end
				ALU_LOGIC: begin
					st_d[ST_ZERO] = (alu.result == READ_ZERO); // [R16]
				end
				ALU_NONE: begin
					// flags keep their value, or what software has just written
				end
			endcase
			if (instr.op == OP_SLEEP) begin
				st_d[ST_PD] = 1'b0; // [R17]
				st_d[ST_TO] = 1'b1; // [R18]
			end
			if (instr.op == OP_WDT_CLEAR) begin
				st_d[ST_PD] = 1'b1; // [R17]
				st_d[ST_TO] = 1'b1; // [R18]
			end
		end
		// timeout arrives last so it is never lost to a clear
		if (wdt_timeout) begin
			st_d[ST_TO] = 1'b0; // [R18]
		end
	end

	// register stage for all outputs except timer0_count_q, which u_timer0 registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pc_q <= PC_RST; // [R9]
			core_status_q <= STATUS_RST; // [R17] [R18] [R19] [R20]
			rd_data_q <= READ_ZERO;
			rd_valid_q <= 1'b0;
			stack_push_q <= 1'b0;
			stack_data_q <= PC_RST;
			mem_req_q <= '0;
		end else if (clk_en) begin
			pc_q <= pc_d;
			core_status_q <= st_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			stack_push_q <= push_d;
			stack_data_q <= push_data_d;
			mem_req_q <= req_d;
		end
	end
endmodule : csp_core_sfr
`default_nettype wire

// [verif/csp_exec_model.sv]
// execution-unit model: issues instructions, holds the stack top
`timescale 1ns/1ps
`default_nettype none
module csp_exec_model import csp_pkg::*; (
	input wire logic mclk, // clock
	input wire logic rstn, // reset
	input wire logic go, // issue request
	input wire csp_instr_t req, // instruction to issue
	input wire logic push, // push pulse
	input wire logic [10:0] push_data, // return address
	output logic exec_valid, // completion
	output csp_instr_t instr, // fields
	output logic [10:0] top_q // stack top
);
	// fields are garbage outside the completion cycle, never stale
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			exec_valid <= 1'b0;
			instr <= '0;
			top_q <= 11'h000;
		end else begin
			exec_valid <= go;
			instr <= go ? req : ~req;
			if (push) top_q <= push_data;
		end
	end
endmodule : csp_exec_model
`default_nettype wire

// [verif/csp_core_sfr_chk.sv]
// port assertions of the core sfr block
`timescale 1ns/1ps
`default_nettype none
module csp_core_sfr_chk import csp_pkg::*; (
	input wire logic mclk, // clock
	input wire logic rstn, // reset
	input wire logic clk_en, // run
	input wire logic exec_valid, // taken
	input wire csp_instr_t instr, // instruction
	input wire csp_alu_res_t alu, // alu result
	input wire logic wdt_timeout, // timeout
	input wire logic [2:0] pc_high_buffer, // pc high stage
	input wire logic [10:0] pc_q, // pc
	input wire logic [7:0] core_status_q, // status
	input wire logic stack_push_q, // push
	input wire logic [10:0] stack_data_q, // return address
	input wire csp_mem_req_t mem_req_q // memory request
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// one instruction class taken at this edge
	sequence s_take(csp_op_t o);
		clk_en && exec_valid && instr.op == o;
	endsequence
	// an alu result of one kind taken
	sequence s_alu(csp_alu_t k);
		clk_en && exec_valid && alu.kind == k;
	endsequence
	AST_JUMP: assert property (s_take(OP_LONG_JUMP) |=> pc_q == $past(instr.target))
		else $error("long jump target not loaded");
	AST_CALL: assert property (s_take(OP_LONG_CALL) |=>
		stack_push_q && stack_data_q == $past(pc_q) + PC_STEP)
		else $error("long call return address wrong");
	AST_STEP: assert property (s_take(OP_SLEEP) |=> pc_q == $past(pc_q) + PC_STEP)
		else $error("pc did not advance by one");
	AST_PCWR: assert property (s_take(OP_GENERAL) ##0 (instr.wr && instr.addr == ADDR_PC_LOW)
		|=> pc_q == {$past(pc_high_buffer), $past(instr.wdata)})
		else $error("pc low write did not form target");
	AST_SLEEP: assert property (s_take(OP_SLEEP) ##0 !wdt_timeout |=>
		core_status_q[ST_TO] && !core_status_q[ST_PD])
		else $error("sleep flags wrong");
	AST_CLR: assert property (s_take(OP_WDT_CLEAR) ##0 !wdt_timeout |=>
		core_status_q[ST_TO] && core_status_q[ST_PD])
		else $error("watchdog clear flags wrong");
	AST_TOUT: assert property (clk_en && wdt_timeout |=> !core_status_q[ST_TO])
		else $error("timeout did not clear flag");
	AST_ZERO: assert property (s_alu(ALU_LOGIC) |=>
		core_status_q[ST_ZERO] == ($past(alu.result) == READ_ZERO))
		else $error("zero flag wrong");
	AST_SUB: assert property (s_alu(ALU_SUB) |=> core_status_q[ST_CARRY] != $past(alu.carry))
		else $error("subtract carry wrong");
	AST_FPAGE: assert property (mem_req_q.valid && mem_req_q.page == PG_F |->
		mem_req_q.bank == BANK_NONE && $past(instr.op) inside {OP_F_WR, OP_F_RD})
		else $error("f page request wrong");
endmodule : csp_core_sfr_chk
bind csp_core_sfr csp_core_sfr_chk u_chk (.mclk, .rstn, .clk_en, .exec_valid, .instr, .alu,
	.wdt_timeout, .pc_high_buffer, .pc_q, .core_status_q, .stack_push_q, .stack_data_q,
	.mem_req_q);
`default_nettype wire

// [verif/tb_top.sv]
// testbench of the core sfr block
`timescale 1ns/1ps
`default_nettype none
module tb_top import csp_pkg::*; ;
	localparam csp_alu_res_t NA = '0;
	logic mclk, rstn = 1'b0, clk_en = 1'b1, go = 1'b0, wdt_timeout = 1'b0;
	logic instruction_clock = 1'b0, external_count_pin = 1'b0, lfo_pin = 1'b0;
	logic timer0_source_mode = T0_MODE_INST, cfg_lfo_sel = 1'b0;
	logic [7:0] file_select_pointer = 8'h00;
	logic [2:0] pc_high_buffer = 3'h0;
	csp_instr_t req = '0, instr;
	csp_alu_res_t alu = '0;
	logic exec_valid, rd_valid_q, stack_push_q;
	logic [10:0] pc_q, stack_data_q, top_q;
	logic [7:0] core_status_q, timer0_count_q, rd_data_q;
	csp_mem_req_t mem_req_q;
	int err_count = 0, samples_checked = 0, cyc = 0;
	csp_exec_model u_exec (.mclk, .rstn, .go, .req, .push(stack_push_q),
		.push_data(stack_data_q), .exec_valid, .instr, .top_q);
	csp_core_sfr u_dut (.mclk, .rstn, .clk_en, .exec_valid, .instr, .alu, .wdt_timeout,
		.file_select_pointer, .pc_high_buffer, .instruction_clock, .external_count_pin,
		.lfo_pin, .timer0_source_mode, .cfg_lfo_sel, .pc_q, .core_status_q, .timer0_count_q,
		.rd_data_q, .rd_valid_q, .stack_push_q, .stack_data_q, .mem_req_q);
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			results();
		end
	end
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic mchk(input csp_page_t p, input logic [1:0] b, input logic [6:0] l,
		input logic [1:0] rw, input logic [7:0] wd);
		chk("mem page", 11'(p), 11'(mem_req_q.page));
		chk("mem bank loc", 11'({1'b1, b, l}), 11'({mem_req_q.valid, mem_req_q.bank, mem_req_q.loc}));
		chk("mem rw data", 11'({rw, wd}), 11'({mem_req_q.rd, mem_req_q.wr, mem_req_q.wdata}));
	endtask : mchk
	// one instruction through the model; returns once its results have landed
	task automatic ex(input csp_op_t op, input logic [1:0] rw, input logic [6:0] ad,
		input logic [7:0] wd, input logic [10:0] tg, input csp_alu_res_t a);
		@(posedge mclk) #1;
		go = 1'b1;
		req = '{op, rw[1], rw[0], ad, wd, tg};
		alu = a;
		@(posedge mclk) #1;
		go = 1'b0;
		@(posedge mclk) #1;
	endtask : ex
	task automatic t_pc;
		chk("pc reset", 11'h000, pc_q);
		chk("status reset", 11'h018, 11'(core_status_q));
		ex(OP_GENERAL, 2'b00, 7'h40, 8'h00, 11'h000, NA);
		chk("pc step", 11'h001, pc_q);
		pc_high_buffer = 3'h5;
		ex(OP_GENERAL, 2'b01, ADDR_PC_LOW, 8'h34, 11'h000, NA);
		chk("pc load", 11'h534, pc_q);
		ex(OP_GENERAL, 2'b10, ADDR_PC_LOW, 8'h00, 11'h000, NA);
		chk("pcl read", 11'h034, 11'(rd_data_q));
		chk("pcl read valid", 11'h001, 11'(rd_valid_q));
		ex(OP_LONG_JUMP, 2'b00, 7'h00, 8'h00, 11'h7FF, NA);
		chk("jump", 11'h7FF, pc_q);
		// step off the top so the pushed address differs from the stack's reset value
		ex(OP_GENERAL, 2'b00, 7'h40, 8'h00, 11'h000, NA);
		chk("pc wrap", 11'h000, pc_q);
		ex(OP_LONG_CALL, 2'b00, 7'h00, 8'h00, 11'h123, NA);
		chk("call", 11'h123, pc_q);
		chk("push", 11'h001, 11'(stack_push_q));
		chk("return addr", 11'h001, stack_data_q);
		@(posedge mclk) #1;
		chk("stack top", 11'h001, top_q);
		chk("push drop", 11'h000, 11'(stack_push_q));
		$display("test pc done");
	endtask : t_pc
	task automatic t_status;
		ex(OP_GENERAL, 2'b00, 7'h40, 8'h00, 11'h000, '{ALU_ADD, 1'b1, 1'b0, 8'h00});
		chk("add flags", 11'h019, 11'(core_status_q));
		ex(OP_GENERAL, 2'b00, 7'h40, 8'h00, 11'h000, '{ALU_SUB, 1'b1, 1'b0, 8'h00});
		chk("sub flags", 11'h01A, 11'(core_status_q));
		ex(OP_GENERAL, 2'b00, 7'h40, 8'h00, 11'h000, '{ALU_LOGIC, 1'b0, 1'b0, 8'h00});
		chk("zero set", 11'h01E, 11'(core_status_q));
		ex(OP_GENERAL, 2'b00, 7'h40, 8'h00, 11'h000, '{ALU_LOGIC, 1'b0, 1'b0, 8'h05});
		chk("zero clear", 11'h01A, 11'(core_status_q));
		// zero bit written high while it is low: software must be able to set it
		ex(OP_GENERAL, 2'b01, ADDR_STATUS, 8'hE4, 11'h000, NA);
		chk("status write", 11'h0E4, 11'(core_status_q));
		ex(OP_SLEEP, 2'b00, 7'h00, 8'h00, 11'h000, NA);
		chk("sleep", 11'h0F4, 11'(core_status_q));
		ex(OP_WDT_CLEAR, 2'b00, 7'h00, 8'h00, 11'h000, NA);
		chk("wdt clear", 11'h0FC, 11'(core_status_q));
		wdt_timeout = 1'b1;
		@(posedge mclk) #1;
		wdt_timeout = 1'b0;
		chk("timeout", 11'h0EC, 11'(core_status_q));
		$display("test status done");
	endtask : t_status
	task automatic t_mem;
		ex(OP_GENERAL, 2'b10, 7'h40, 8'h00, 11'h000, NA);
		mchk(PG_R, 2'h3, 7'h40, 2'b10, 8'h00);
		ex(OP_F_WR, 2'b01, 7'h05, 8'h11, 11'h000, NA);
		mchk(PG_F, 2'h0, 7'h05, 2'b01, 8'h11);
		ex(OP_S_RD, 2'b10, 7'h05, 8'h00, 11'h000, NA);
		mchk(PG_S, 2'h0, 7'h05, 2'b10, 8'h00);
		ex(OP_T_WR, 2'b01, 7'h05, 8'h22, 11'h000, NA);
		mchk(PG_T, 2'h3, 7'h05, 2'b01, 8'h22);
		file_select_pointer = 8'h85;
		ex(OP_GENERAL, 2'b10, ADDR_INDIRECT, 8'h00, 11'h000, NA);
		mchk(PG_R, 2'h3, 7'h05, 2'b10, 8'h00);
		$display("test mem done");
	endtask : t_mem
	task automatic t_timer;
		ex(OP_GENERAL, 2'b01, ADDR_TIMER0, 8'hFF, 11'h000, NA);
		chk("t0 write", 11'h0FF, 11'(timer0_count_q));
		chk("t0 write local", 11'h000, 11'(mem_req_q.valid));
		instruction_clock = 1'b1;
		repeat (3) @(posedge mclk);
		#1 instruction_clock = 1'b0;
		chk("t0 ticks", 11'h002, 11'(timer0_count_q));
		ex(OP_GENERAL, 2'b10, ADDR_TIMER0, 8'h00, 11'h000, NA);
		chk("t0 read", 11'h002, 11'(rd_data_q));
		timer0_source_mode = 1'b1;
		external_count_pin = 1'b1;
		repeat (5) @(posedge mclk);
		#1 external_count_pin = 1'b0;
		chk("t0 pin", 11'h003, 11'(timer0_count_q));
		cfg_lfo_sel = T0_CFG_LFO;
		lfo_pin = 1'b1;
		repeat (5) @(posedge mclk);
		#1 lfo_pin = 1'b0;
		chk("t0 lfo", 11'h004, 11'(timer0_count_q));
		// ticks offered while the enable is low must not count
		timer0_source_mode = T0_MODE_INST;
		clk_en = 1'b0;
		instruction_clock = 1'b1;
		repeat (3) @(posedge mclk);
		#1 instruction_clock = 1'b0;
		clk_en = 1'b1;
		chk("t0 frozen", 11'h004, 11'(timer0_count_q));
		$display("test timer done");
	endtask : t_timer
	// reset, then the scenarios in order
	initial begin
		repeat (6) @(posedge mclk);
		#1 rstn = 1'b1;
		t_pc();
		t_status();
		t_mem();
		t_timer();
		results();
	end
endmodule : tb_top
`default_nettype wire
